// >>> hdl/ecb_pkg.sv
// Package for the external-control word transfer block.
// Assumes byte offsets decoded from the low eight AXI address bits.
package ecb_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_EXT_ACCESS  = 8'h00;
  localparam logic [7:0] ADDR_MACH_STATE  = 8'h04;
  localparam logic [7:0] ADDR_SEG_TYPE    = 8'h08;
  localparam logic [7:0] ADDR_EFF_ADDR    = 8'h0C;
  localparam logic [7:0] ADDR_SRC_DATA    = 8'h10;
  localparam logic [7:0] ADDR_COMMAND     = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;
  localparam logic [7:0] ADDR_LOAD_DATA   = 8'h1C;
  localparam int         ADDR_W           = 8;

  // Field positions
  localparam int RID_W          = 4;   // resource_identifier width
  localparam int RID_MSB        = 3;   // identifier bit 28, big-endian
  localparam int DR_BIT         = 0;   // data_relocate_bit
  localparam int SEG_CNT        = 16;
  localparam int SEG_SEL_LSB    = 28;  // effective_address[0:3]
  localparam int CMD_START_BIT  = 0;
  localparam int CMD_OUT_BIT    = 1;   // 1 = output word, 0 = input word
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_ALIGN_BIT   = 2;
  localparam int ST_DSI_BIT     = 3;
  localparam int ST_RELOC_BIT   = 4;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0]  RST_RID  = 4'h0;
  localparam logic [15:0] RST_SEG  = 16'h0000;

  // Transfer size and alignment
  localparam int         XFER_BYTES = 4;
  localparam logic [1:0] ALIGN_MASK = 2'(XFER_BYTES - 1);

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    XF_IDLE  = 2'b00,
    XF_START = 2'b01,
    XF_WAIT  = 2'b11
  } ecb_xfer_state_t;
endpackage

// >>> hdl/ecb_bus_xfer.sv
// Bus engine for one external-control word transfer.
// Assumes the device holds ack and read data together for three clocks.
`timescale 1ns/1ps
module ecb_bus_xfer
  import ecb_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Request from register side
  input  wire logic              launch,
  input  wire logic              outDir,
  input  wire logic [RID_W-1:0]  resource_identifier,
  input  wire logic [31:0]       addr,
  input  wire logic [31:0]       wrWord,
  output logic                   xferDone,
  output logic [31:0]            rdWord,
  // System bus pins
  output logic [31:0]            busAddr,
  output logic                   burstFlagLine,
  output logic [2:0]             transferSizeLines,
  output logic                   busStart,
  output logic                   busWrite,
  output logic [31:0]            busDataOut,
  output logic                   busDataOe,
  input  wire logic              busAck,
  input  wire logic [31:0]       busDataIn
);
  ecb_xfer_state_t state_r, state_nxt;
  logic        ackS1_r, ackS2_r;
  logic [31:0] dinS1_r, dinS2_r;
  logic        done_nxt, start_nxt, write_nxt, oe_nxt, flag_nxt;
  logic [2:0]  size_nxt;
  logic [31:0] addr_nxt, dout_nxt, rd_nxt;

  always_comb begin
    state_nxt = state_r;
    done_nxt  = 1'b0;
    start_nxt = 1'b0;
    write_nxt = busWrite;
    oe_nxt    = busDataOe;
    flag_nxt  = burstFlagLine;
    size_nxt  = transferSizeLines;
    addr_nxt  = busAddr;
    dout_nxt  = busDataOut;
    rd_nxt    = rdWord;
    unique case (state_r)
      XF_IDLE: begin
        if (launch) begin
          state_nxt = XF_START;
          addr_nxt  = addr;
          flag_nxt  = resource_identifier[RID_MSB];
          size_nxt  = resource_identifier[2:0];
          write_nxt = outDir;
          dout_nxt  = wrWord;
          oe_nxt    = outDir;
        end
      end
      XF_START: begin
        // Stale ack from a prior transfer must drain first
        if (!ackS2_r) begin
          start_nxt = 1'b1;
          state_nxt = XF_WAIT;
        end
      end
      XF_WAIT: begin
        if (ackS2_r && !busStart) begin
          done_nxt  = 1'b1;
          state_nxt = XF_IDLE;
          if (!busWrite) begin
            rd_nxt = dinS2_r;
          end
          oe_nxt    = 1'b0;
          write_nxt = 1'b0;
          flag_nxt  = 1'b0;
          size_nxt  = 3'h0;
        end
      end
      default: state_nxt = XF_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r           <= XF_IDLE;
      ackS1_r           <= 1'b0;
      ackS2_r           <= 1'b0;
      dinS1_r           <= RST_WORD;
      dinS2_r           <= RST_WORD;
      xferDone          <= 1'b0;
      rdWord            <= RST_WORD;
      busAddr           <= RST_WORD;
      burstFlagLine     <= 1'b0;
      transferSizeLines <= 3'h0;
      busStart          <= 1'b0;
      busWrite          <= 1'b0;
      busDataOut        <= RST_WORD;
      busDataOe         <= 1'b0;
    end else begin
      state_r           <= state_nxt;
      ackS1_r           <= busAck;
      ackS2_r           <= ackS1_r;
      dinS1_r           <= busDataIn;
      dinS2_r           <= dinS1_r;
      xferDone          <= done_nxt;
      rdWord            <= rd_nxt;
      busAddr           <= addr_nxt;
      burstFlagLine     <= flag_nxt;
      transferSizeLines <= size_nxt;
      busStart          <= start_nxt;
      busWrite          <= write_nxt;
      busDataOut        <= dout_nxt;
      busDataOe         <= oe_nxt;
    end
  end
endmodule

// >>> hdl/ecb_top.sv
// External-control word transfer block with AXI4-Lite registers.
// Assumes one ref_clk domain; bus pins are synchronised in the engine.
//
// Behaviour
// - Each transfer is one four-byte word.
// - Identifier drives burst and size lines.
// - Burst line carries identifier most significant bit.
// - Misaligned address raises alignment fault, no transfer.
// - Segment type one raises storage fault, no transfer.
// - Relocation off flags error; address undefined.
// - Effective address goes out on address bus.
// - Input word is loaded into destination register.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module ecb_top
  import ecb_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // System bus pins
  output logic [31:0]            busAddr,
  output logic                   burstFlagLine,
  output logic [2:0]             transferSizeLines,
  output logic                   busStart,
  output logic                   busWrite,
  output logic [31:0]            busDataOut,
  output logic                   busDataOe,
  input  wire logic              busAck,
  input  wire logic [31:0]       busDataIn
);
  // Bus slave state
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic              awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [31:0]       wData_r, wData_nxt;
  logic [3:0]        wStrb_r, wStrb_nxt;
  logic              awRdy_nxt, wRdy_nxt, bValid_nxt, arRdy_nxt, rValid_nxt;
  logic [1:0]        bResp_nxt, rResp_nxt;
  logic [31:0]       rData_nxt;
  // Block state
  logic [RID_W-1:0]   rid_r, rid_nxt;
  logic               reloc_r, reloc_nxt;
  logic [SEG_CNT-1:0] segType_r, segType_nxt;
  logic [31:0]        effAddr_r, effAddr_nxt, srcData_r, srcData_nxt;
  logic [31:0]        loadData_r, loadData_nxt;
  logic               busy_r, busy_nxt, done_r, done_nxt;
  logic               alignErr_r, alignErr_nxt, dsiErr_r, dsiErr_nxt;
  logic               relocErr_r, relocErr_nxt;
  logic               launch_r, launch_nxt, outDir_r, outDir_nxt;
  logic               xferDone;
  logic [31:0]        rdWord;
  logic [31:0]        statusWord, wrMerged;
  logic               doWrite, startReq;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    statusWord               = RST_WORD;
    statusWord[ST_BUSY_BIT]  = busy_r;
    statusWord[ST_DONE_BIT]  = done_r;
    statusWord[ST_ALIGN_BIT] = alignErr_r;
    statusWord[ST_DSI_BIT]   = dsiErr_r;
    statusWord[ST_RELOC_BIT] = relocErr_r;
  end

  // Write channel capture, in either order
  always_comb begin
    awAddr_nxt = awAddr_r;
    awHeld_nxt = awHeld_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    wHeld_nxt  = wHeld_r;
    bValid_nxt = s_axi_bvalid;
    bResp_nxt  = s_axi_bresp;
    doWrite    = awHeld_r && wHeld_r && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      awAddr_nxt = s_axi_awaddr;
      awHeld_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
      wHeld_nxt = 1'b1;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = (awAddr_r <= ADDR_LOAD_DATA && awAddr_r[1:0] == 2'b00)
                   ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    awRdy_nxt = !awHeld_nxt;
    wRdy_nxt  = !wHeld_nxt;
  end

  // Read channel
  always_comb begin
    arRdy_nxt  = s_axi_arready || !s_axi_rvalid;
    rValid_nxt = s_axi_rvalid;
    rData_nxt  = s_axi_rdata;
    rResp_nxt  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      arRdy_nxt  = 1'b0;
      rValid_nxt = 1'b1;
      rResp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_EXT_ACCESS: rData_nxt = 32'(rid_r);
        ADDR_MACH_STATE: rData_nxt = 32'(reloc_r);
        ADDR_SEG_TYPE:   rData_nxt = 32'(segType_r);
        ADDR_EFF_ADDR:   rData_nxt = effAddr_r;
        ADDR_SRC_DATA:   rData_nxt = srcData_r;
        ADDR_COMMAND:    rData_nxt = RST_WORD;
        ADDR_STATUS:     rData_nxt = statusWord;
        ADDR_LOAD_DATA:  rData_nxt = loadData_r;
        default: begin
          rData_nxt = RST_WORD;
          rResp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rValid_nxt = 1'b0;
      arRdy_nxt  = 1'b1;
    end
  end

  // Register writes, command checks and status
  always_comb begin
    rid_nxt      = rid_r;
    reloc_nxt    = reloc_r;
    segType_nxt  = segType_r;
    effAddr_nxt  = effAddr_r;
    srcData_nxt  = srcData_r;
    loadData_nxt = loadData_r;
    busy_nxt     = busy_r;
    done_nxt     = done_r;
    alignErr_nxt = alignErr_r;
    dsiErr_nxt   = dsiErr_r;
    relocErr_nxt = relocErr_r;
    launch_nxt   = 1'b0;
    outDir_nxt   = outDir_r;
    startReq     = 1'b0;
    wrMerged     = RST_WORD;
    if (doWrite) begin
      unique case (awAddr_r)
        ADDR_EXT_ACCESS: begin
          wrMerged = merge(32'(rid_r), wData_r, wStrb_r);
          rid_nxt  = wrMerged[RID_W-1:0];
        end
        ADDR_MACH_STATE: begin
          wrMerged  = merge(32'(reloc_r), wData_r, wStrb_r);
          reloc_nxt = wrMerged[DR_BIT];
        end
        ADDR_SEG_TYPE: begin
          wrMerged    = merge(32'(segType_r), wData_r, wStrb_r);
          segType_nxt = wrMerged[SEG_CNT-1:0];
        end
        ADDR_EFF_ADDR: effAddr_nxt = merge(effAddr_r, wData_r, wStrb_r);
        ADDR_SRC_DATA: srcData_nxt = merge(srcData_r, wData_r, wStrb_r);
        ADDR_COMMAND: begin
          // A start while busy is dropped; software polls busy
          if (wStrb_r[0] && wData_r[CMD_START_BIT] && !busy_r) begin
            startReq   = 1'b1;
            outDir_nxt = wData_r[CMD_OUT_BIT];
          end
        end
        ADDR_STATUS: begin
          if (wStrb_r[0]) begin
            done_nxt     = done_r && !wData_r[ST_DONE_BIT];
            alignErr_nxt = alignErr_r && !wData_r[ST_ALIGN_BIT];
            dsiErr_nxt   = dsiErr_r && !wData_r[ST_DSI_BIT];
            relocErr_nxt = relocErr_r && !wData_r[ST_RELOC_BIT];
          end
        end
        default: ;
      endcase
    end
    // Sets below override clears above
    if (startReq) begin
      if ((effAddr_r[1:0] & ALIGN_MASK) != 2'b00) begin
        alignErr_nxt = 1'b1;
      end else if (segType_r[effAddr_r[31:SEG_SEL_LSB]]) begin
        dsiErr_nxt = 1'b1;
      end else begin
        launch_nxt = 1'b1;
        busy_nxt   = 1'b1;
        // Address is sent anyway but is meaningless
        if (!reloc_r) begin
          relocErr_nxt = 1'b1;
        end
      end
    end
    if (xferDone) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
      if (!outDir_r) begin
        loadData_nxt = rdWord;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awAddr_r      <= '0;
      awHeld_r      <= 1'b0;
      wData_r       <= RST_WORD;
      wStrb_r       <= 4'h0;
      wHeld_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= RST_WORD;
      s_axi_rresp   <= RESP_OKAY;
      rid_r         <= RST_RID;
      reloc_r       <= 1'b0;
      segType_r     <= RST_SEG;
      effAddr_r     <= RST_WORD;
      srcData_r     <= RST_WORD;
      loadData_r    <= RST_WORD;
      busy_r        <= 1'b0;
      done_r        <= 1'b0;
      alignErr_r    <= 1'b0;
      dsiErr_r      <= 1'b0;
      relocErr_r    <= 1'b0;
      launch_r      <= 1'b0;
      outDir_r      <= 1'b0;
    end else begin
      awAddr_r      <= awAddr_nxt;
      awHeld_r      <= awHeld_nxt;
      wData_r       <= wData_nxt;
      wStrb_r       <= wStrb_nxt;
      wHeld_r       <= wHeld_nxt;
      s_axi_awready <= awRdy_nxt;
      s_axi_wready  <= wRdy_nxt;
      s_axi_bvalid  <= bValid_nxt;
      s_axi_bresp   <= bResp_nxt;
      s_axi_arready <= arRdy_nxt;
      s_axi_rvalid  <= rValid_nxt;
      s_axi_rdata   <= rData_nxt;
      s_axi_rresp   <= rResp_nxt;
      rid_r         <= rid_nxt;
      reloc_r       <= reloc_nxt;
      segType_r     <= segType_nxt;
      effAddr_r     <= effAddr_nxt;
      srcData_r     <= srcData_nxt;
      loadData_r    <= loadData_nxt;
      busy_r        <= busy_nxt;
      done_r        <= done_nxt;
      alignErr_r    <= alignErr_nxt;
      dsiErr_r      <= dsiErr_nxt;
      relocErr_r    <= relocErr_nxt;
      launch_r      <= launch_nxt;
      outDir_r      <= outDir_nxt;
    end
  end

  ecb_bus_xfer u_xfer (
    .ref_clk           (ref_clk),
    .rst               (rst),
    .launch            (launch_r),
    .outDir            (outDir_r),
    .resource_identifier               (rid_r),
    .addr              (effAddr_r),
    .wrWord            (srcData_r),
    .xferDone          (xferDone),
    .rdWord            (rdWord),
    .busAddr           (busAddr),
    .burstFlagLine     (burstFlagLine),
    .transferSizeLines (transferSizeLines),
    .busStart          (busStart),
    .busWrite          (busWrite),
    .busDataOut        (busDataOut),
    .busDataOe         (busDataOe),
    .busAck            (busAck),
    .busDataIn         (busDataIn)
  );
endmodule

// >>> verification/ecb_top_sva.sv
// Checker for the external-control transfer block, top ports only.
// Assumes one ref_clk domain and one AXI write in flight at a time.
`timescale 1ns/1ps
module ecb_top_sva
  import ecb_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // AXI4-Lite writes
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  // System bus pins
  input wire logic [31:0]       busAddr,
  input wire logic              burstFlagLine,
  input wire logic [2:0]        transferSizeLines,
  input wire logic              busStart,
  input wire logic              busWrite,
  input wire logic [31:0]       busDataOut,
  input wire logic              busDataOe,
  input wire logic              busAck
);
  logic [ADDR_W-1:0] awSh;
  logic [3:0]        stSh;
  logic [31:0]       wSh, ridSh, eaSh, srcSh, segSh;

  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] n,
                                      logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ridSh <= RST_WORD;
      eaSh  <= RST_WORD;
      srcSh <= RST_WORD;
      segSh <= RST_WORD;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSh <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wSh  <= s_axi_wdata;
        stSh <= s_axi_wstrb;
      end
      // Commit on OKAY only; refused writes leave shadows
      if ($rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY) begin
        case (awSh)
          ADDR_EXT_ACCESS: ridSh <= mrg(ridSh, wSh, stSh);
          ADDR_EFF_ADDR:   eaSh  <= mrg(eaSh, wSh, stSh);
          ADDR_SRC_DATA:   srcSh <= mrg(srcSh, wSh, stSh);
          ADDR_SEG_TYPE:   segSh <= mrg(segSh, wSh, stSh);
          default: ;
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_ack_rise;
    $rose(busAck);
  endsequence
  sequence s_idle_pins;
    !burstFlagLine && transferSizeLines == 3'h0 && !busDataOe;
  endsequence

  a_rid_lines:
    assert property (busStart |->
      {burstFlagLine, transferSizeLines} == ridSh[RID_W-1:0])
    else $error("identifier lines differ from register");
  a_addr_passed:
    assert property (busStart |-> busAddr == eaSh)
    else $error("bus address differs from effective address");
  a_write_word:
    assert property (busStart && busWrite |->
      busDataOe && busDataOut == srcSh)
    else $error("output word not driven");
  a_read_undriven:
    assert property (busStart && !busWrite |-> !busDataOe)
    else $error("data driven during input word");
  a_single_beat:
    assert property (busStart |=> !busStart [*3])
    else $error("more than one start for one word");
  a_pins_held:
    assert property (busStart |=> $stable({burstFlagLine,
      transferSizeLines, busAddr, busWrite}) [*2])
    else $error("transfer pins moved during transfer");
  a_align_only:
    assert property (busStart |-> busAddr[1:0] == 2'h0)
    else $error("misaligned address reached the bus");
  a_seg_clear:
    assert property (busStart |-> !segSh[busAddr[31:28]])
    else $error("transfer into a flagged segment");
  a_idle_after:
    assert property (s_ack_rise |-> ##[2:8] s_idle_pins)
    else $error("identifier lines not released after ack");
endmodule

bind ecb_top ecb_top_sva ecb_top_sva_inst (.*);

// >>> verification/ecb_dev_model.sv
// Special-purpose device on the far side of the system bus.
// Assumes one transfer at a time; answers after a bench-set delay.
`timescale 1ns/1ps
module ecb_dev_model
  import ecb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Bus pins from the block
  input  wire logic [31:0] busAddr,
  input  wire logic        burstFlagLine,
  input  wire logic [2:0]  transferSizeLines,
  input  wire logic        busStart,
  input  wire logic        busWrite,
  input  wire logic [31:0] busDataOut,
  input  wire logic        busDataOe,
  output logic             busAck,
  output logic [31:0]      busDataIn,
  // Bench controls and observations
  input  wire logic [3:0]  myRid,
  input  wire logic [3:0]  ackDelay,
  input  wire logic [31:0] rdWord,
  output logic [31:0]      gotAddr,
  output logic [31:0]      gotWord,
  output logic [7:0]       hits
);
  logic [3:0] waitCnt;
  logic [1:0] holdCnt;
  logic       armed;

  always @(posedge ref_clk) begin
    if (rst) begin
      busAck <= 1'b0;
      armed <= 1'b0;
      holdCnt <= 2'h0;
      waitCnt <= 4'h0;
      hits <= 8'h00;
      busDataIn <= 32'h0000_0000;
      gotAddr <= 32'h0000_0000;
      gotWord <= 32'h0000_0000;
    end else if (busStart && {burstFlagLine, transferSizeLines} == myRid) begin
      // Picked by identifier lines only
      armed <= 1'b1;
      waitCnt <= ackDelay;
      hits <= hits + 8'h01;
      gotAddr <= busAddr;
      if (busWrite && busDataOe) begin
        gotWord <= busDataOut;
      end
    end else if (armed && waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end else if (armed) begin
      // Ack and word held three cycles for the synchroniser
      armed <= 1'b0;
      busAck <= 1'b1;
      holdCnt <= 2'h2;
      busDataIn <= rdWord;
    end else if (holdCnt != 2'h0) begin
      holdCnt <= holdCnt - 2'h1;
    end else if (busAck) begin
      // Released bus shows the inverse
      busAck <= 1'b0;
      busDataIn <= ~busDataIn;
    end
  end
endmodule

// >>> verification/external_control_bus_access_tb_top.sv
// Bench for the external-control transfer block over AXI4-Lite.
// Assumes the device model answers only its own identifier.
`timescale 1ns/1ps
module external_control_bus_access_tb_top
  import ecb_pkg::*;
;
  logic              ref_clk, rst, s_axi_awvalid, s_axi_awready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, busAddr, busDataOut;
  logic [31:0]       busDataIn, rdWord, gotAddr, gotWord;
  logic [3:0]        s_axi_wstrb, myRid, ackDelay;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready, burstFlagLine;
  logic              busStart, busWrite, busDataOe, busAck;
  logic [2:0]        transferSizeLines;
  logic [7:0]        hits;
  int                checks = 0, num_errors = 0;

  ecb_top ecb_top_inst (.*);
  ecb_dev_model ecb_dev_model_inst (.*);

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic bail(string what);
    num_errors++;
    $display("MISMATCH %s expected answer seen none", what);
    summarize();
  endtask

  task automatic cmp_word(string what, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_resp(string what, logic [1:0] e, logic [1:0] g);
    cmp_word(what, 32'(e), 32'(g));
  endtask

  task automatic axi_wr(logic [ADDR_W-1:0] a, logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 60) begin
      bail("write response");
    end
  endtask

  task automatic axi_rd(logic [ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 60) begin
      bail("read data");
    end
  endtask

  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    cmp_resp("write response", RESP_OKAY, r);
  endtask

  task automatic rd_chk(string what, logic [ADDR_W-1:0] a, logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    cmp_resp("read response", RESP_OKAY, r);
    cmp_word(what, e, d);
  endtask

  task automatic wait_bit(int b, output logic [31:0] st);
    logic [1:0] r;
    int         n;
    for (n = 0; n < 40; n++) begin
      axi_rd(ADDR_STATUS, st, r);
      if (st[b] === 1'b1) begin
        break;
      end
    end
    if (n == 40) begin
      bail("status flag");
    end
  endtask

  task automatic start(logic [31:0] ea, logic [31:0] cmd);
    wr(ADDR_EFF_ADDR, ea);
    wr(ADDR_COMMAND, cmd);
  endtask

  initial begin
    logic [31:0] d, st, ea;
    logic [1:0]  r;
    int          h;
    {rst, s_axi_wstrb} = {1'b1, 4'hF};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, myRid, ackDelay, rdWord} = '0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk("reset value", 8'(4 * i), RST_WORD);
    end
    axi_rd(8'h20, d, r);
    cmp_resp("unmapped read", RESP_SLVERR, r);
    cmp_word("unmapped data", 32'h0000_0000, d);
    axi_wr(8'h24, 32'hFFFF_FFFF, r);
    cmp_resp("unmapped write", RESP_SLVERR, r);
    $display("test reset_map done");
    wr(ADDR_MACH_STATE, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      myRid <= 4'(i);
      ackDelay <= 4'(15 - i);
      rdWord <= 32'hC0DE_0000 | 32'(i);
      ea = 32'h3000_0000 | 32'(i << 4);
      wr(ADDR_EXT_ACCESS, 32'(i));
      start(ea, 32'h0000_0001);
      wait_bit(ST_DONE_BIT, st);
      cmp_word("input status", 32'h0000_0001 << ST_DONE_BIT, st);
      rd_chk("load word", ADDR_LOAD_DATA, 32'hC0DE_0000 | 32'(i));
      cmp_word("device address", ea, gotAddr);
      cmp_word("device hits", 32'(i + 1), 32'(hits));
      wr(ADDR_STATUS, 32'h0000_001E);
    end
    $display("test input_word done");
    myRid <= 4'hA;
    wr(ADDR_EXT_ACCESS, 32'h0000_000A);
    wr(ADDR_SRC_DATA, 32'h5A69_C3F0);
    start(32'h7FFF_FFFC, 32'h0000_0003);
    wait_bit(ST_DONE_BIT, st);
    cmp_word("device word", 32'h5A69_C3F0, gotWord);
    cmp_word("device address", 32'h7FFF_FFFC, gotAddr);
    wr(ADDR_STATUS, 32'h0000_001E);
    $display("test output_word done");
    wr(ADDR_SEG_TYPE, 32'h0000_0020);
    h = hits;
    for (int i = 1; i < 4; i++) begin
      start(32'h5000_0040 | 32'(i), 32'h0000_0001);
      wait_bit(ST_ALIGN_BIT, st);
      d = st & 32'h0000_001D;
      cmp_word("align flags", 32'h0000_0001 << ST_ALIGN_BIT, d);
      wr(ADDR_STATUS, 32'h0000_001E);
    end
    start(32'h5000_0040, 32'h0000_0003);
    wait_bit(ST_DSI_BIT, st);
    d = st & 32'h0000_001D;
    cmp_word("segment flags", 32'h0000_0001 << ST_DSI_BIT, d);
    cmp_word("device hits", 32'(h), 32'(hits));
    wr(ADDR_STATUS, 32'h0000_001E);
    start(32'h4FFF_FFF0, 32'h0000_0001);
    wait_bit(ST_DONE_BIT, st);
    cmp_word("device hits", 32'(h + 1), 32'(hits));
    wr(ADDR_STATUS, 32'h0000_001E);
    $display("test faults done");
    wr(ADDR_MACH_STATE, 32'h0000_0000);
    start(32'h1000_0008, 32'h0000_0001);
    wait_bit(ST_DONE_BIT, st);
    ea = (32'h0000_0001 << ST_DONE_BIT) | (32'h0000_0001 << ST_RELOC_BIT);
    cmp_word("relocation off status", ea, st);
    cmp_word("device hits", 32'(h + 2), 32'(hits));
    $display("test relocation_off done");
    summarize();
  end
endmodule
